/* psst_bank.sv */
// Status and telemetry register bank of the point-of-load converter
`timescale 1ns/1ps

// Function
// - Latched summary flags clear only on clear-faults once the cause is gone.
// - Word bit 15 set for any output-voltage issue (overvoltage and undervoltage live, range and other latched), bit 14 live for overcurrent.
// - Word bit 13 set from power-up until input first passes lockout.
// - Word bit 11 reads inverted power-good, live.
// - Word bit 8 latches unlisted faults; bits 12, 10, 9 read zero.
// - Word low byte equals the status byte register.
// - Output-voltage status bit 7 live overvoltage fault.
// - Output-voltage bit 4 live undervoltage; bits 6,5,2,1 read zero.
// - Output-voltage bit 3 set on out-of-range voltage programming attempt.
// - Output-voltage bit 0 latches unlisted fault types.
// - Input status bit 7 latches overvoltage seen on the sense pin.
// - Input status bit 6 latches input overvoltage warning.
// - Input bit 5 latches undervoltage warning; bits 4..0 read zero.
// - Latched input flags clear on clear-faults only after cause removed.
// - Temperature bits 7 and 6 latch fault and warning; rest zero.
// - Input reading returns 10-bit value, upper bits zero.
// - Output reading returns 10-bit value at 1.25 mV steps, upper zero.
// - Status byte bit 6 live when converter is disabled.
// - Status byte bit 1 latches on a management bus error.
module psst_bank #(
    parameter int MEAS_WIDTH = psst_pkg::MEAS_W // Measurement width
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire psst_pkg::psst_cause_type cause, // Live fault causes
    input wire logic comm_err, // Bus error pulse
    input wire logic clear_faults, // Clear-faults command pulse
    input wire logic [MEAS_WIDTH-1:0] vin_meas, // Input voltage sample
    input wire logic [MEAS_WIDTH-1:0] vout_meas, // Output voltage sample
    input wire logic rd_req, // Read request pulse
    input wire logic [7:0] rd_cmd, // Command code to read
    output logic [15:0] rd_data, // Read data
    output logic rd_valid, // Read answer pulse
    output logic rd_err // Unsupported command pulse
);
    psst_pkg::psst_state_type st_r;
    psst_pkg::psst_state_type st_nxt;
    logic comm_lat_r;
    logic comm_lat_nxt;
    logic [7:0] sb;
    logic [15:0] sw;
    logic [7:0] vo_st;
    logic [7:0] io_st;
    logic [7:0] in_st;
    logic [7:0] t_st;
    logic [7:0] c_st;
    logic [15:0] vin_rd;
    logic [15:0] vout_rd;

    // Status views built from live causes and latched flags
    always_comb begin
        sb = psst_pkg::ZERO8;
        sb[psst_pkg::SB_OFF] = cause.disabled;
        sb[psst_pkg::SB_VOUT_OV] = cause.vout_ov;
        sb[psst_pkg::SB_IOUT_OC] = st_r.lat.iout_oc;
        sb[psst_pkg::SB_TEMP] = cause.ot_fault | cause.ot_warn;
        sb[psst_pkg::SB_COMM] = comm_lat_r;
        sb[psst_pkg::SB_NONE] = st_r.lat.other_fault;
        sw = {psst_pkg::ZERO8, sb};
        sw[psst_pkg::SW_VOUT] = cause.vout_ov | cause.vout_uv
            | st_r.lat.vout_range | st_r.lat.vout_other;
        sw[psst_pkg::SW_IOUT] = cause.iout_oc;
        sw[psst_pkg::SW_VIN] = st_r.vin_startup;
        sw[psst_pkg::SW_PGOOD_N] = ~cause.pgood;
        sw[psst_pkg::SW_OTHER] = st_r.lat.other_fault;
        vo_st = psst_pkg::ZERO8;
        vo_st[psst_pkg::B7] = cause.vout_ov;
        vo_st[psst_pkg::B4] = cause.vout_uv;
        vo_st[psst_pkg::B3] = st_r.lat.vout_range;
        vo_st[psst_pkg::B0] = st_r.lat.vout_other;
        io_st = psst_pkg::ZERO8;
        io_st[psst_pkg::B7] = st_r.lat.iout_oc;
        io_st[psst_pkg::B6] = st_r.lat.iout_oc_uv;
        io_st[psst_pkg::B5] = st_r.lat.iout_warn;
        in_st = psst_pkg::ZERO8;
        in_st[psst_pkg::B7] = st_r.lat.vin_ov_pin;
        in_st[psst_pkg::B6] = st_r.lat.vin_ov_warn;
        in_st[psst_pkg::B5] = st_r.lat.vin_uv_warn;
        t_st = psst_pkg::ZERO8;
        t_st[psst_pkg::B7] = st_r.lat.ot_fault;
        t_st[psst_pkg::B6] = st_r.lat.ot_warn;
        c_st = psst_pkg::ZERO8;
        c_st[psst_pkg::B7] = st_r.lat.cmd_bad;
        c_st[psst_pkg::B6] = st_r.lat.data_bad;
        c_st[psst_pkg::B4] = st_r.lat.mem_fault;
        c_st[psst_pkg::B1] = st_r.lat.comm_other;
        c_st[psst_pkg::B0] = cause.mem_busy; // busy is a live state
        vin_rd = psst_pkg::ZERO16;
        vin_rd[MEAS_WIDTH-1:0] = vin_meas;
        vout_rd = psst_pkg::ZERO16;
        vout_rd[MEAS_WIDTH-1:0] = vout_meas;
    end

    // Latch update: a new event always beats the clear in the same cycle
    always_comb begin
        psst_pkg::psst_latch_type ev;
        psst_pkg::psst_latch_type kept;
        ev = '{vout_other: cause.vout_other, vout_range: cause.vout_range,
            iout_oc: cause.iout_oc, iout_oc_uv: cause.iout_oc_uv,
            iout_warn: cause.iout_warn, vin_ov_pin: cause.vin_ov_pin,
            vin_ov_warn: cause.vin_ov_warn, vin_uv_warn: cause.vin_uv_warn,
            ot_fault: cause.ot_fault, ot_warn: cause.ot_warn,
            other_fault: cause.other_fault, cmd_bad: cause.cmd_bad,
            data_bad: cause.data_bad, mem_fault: cause.mem_fault,
            comm_other: cause.comm_other};
        // Clear drops only flags whose cause is already gone
        kept = clear_faults ? '0 : st_r.lat;
        st_nxt = st_r;
        st_nxt.lat = kept | ev;
        // Start-up flag falls once lockout is passed, never returns
        if (cause.vin_uvlo_ok) begin
            st_nxt.vin_startup = 1'b0;
        end
        comm_lat_nxt = (comm_lat_r & ~clear_faults) | comm_err;
        // Read answer one cycle after the request
        st_nxt.rvalid = rd_req;
        st_nxt.rerr = 1'b0;
        st_nxt.rdata = psst_pkg::ZERO16;
        if (rd_req) begin
            case (rd_cmd)
                psst_pkg::CMD_STATUS_BYTE: st_nxt.rdata = {psst_pkg::ZERO8, sb};
                psst_pkg::CMD_SUMMARY_WORD: st_nxt.rdata = sw;
                psst_pkg::CMD_VOUT_STATUS:
                    st_nxt.rdata = {psst_pkg::ZERO8, vo_st};
                psst_pkg::CMD_IOUT_STATUS:
                    st_nxt.rdata = {psst_pkg::ZERO8, io_st};
                psst_pkg::CMD_INPUT_STATUS:
                    st_nxt.rdata = {psst_pkg::ZERO8, in_st};
                psst_pkg::CMD_TEMP_STATUS:
                    st_nxt.rdata = {psst_pkg::ZERO8, t_st};
                psst_pkg::CMD_COMM_STATUS:
                    st_nxt.rdata = {psst_pkg::ZERO8, c_st};
                psst_pkg::CMD_VIN_READING: st_nxt.rdata = vin_rd;
                psst_pkg::CMD_VOUT_READING: st_nxt.rdata = vout_rd;
                default: st_nxt.rerr = 1'b1; // Unmapped reads return zero
            endcase
        end
    end

    // State registers; start-up flag is set by reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.vin_startup <= 1'b1;
            comm_lat_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            comm_lat_r <= comm_lat_nxt;
        end
    end

    assign rd_data = st_r.rdata;
    assign rd_valid = st_r.rvalid;
    assign rd_err = st_r.rerr;
endmodule

/* psst_bank_sva.sv */
// Assertions on the status bank read port and its flag fields
`timescale 1ns/1ps
module psst_bank_sva #(
    parameter int MEAS_WIDTH = 10 // Measurement width
) (
    input wire logic sys_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire psst_pkg::psst_cause_type cause, // Causes
    input wire logic comm_err, // Bus error
    input wire logic clear_faults, // Clear pulse
    input wire logic [MEAS_WIDTH-1:0] vin_meas, // Input sample
    input wire logic [MEAS_WIDTH-1:0] vout_meas, // Output sample
    input wire logic rd_req, // Request
    input wire logic [7:0] rd_cmd, // Code
    input wire logic [15:0] rd_data, // Data
    input wire logic rd_valid, // Answer
    input wire logic rd_err // Refusal
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Read of one code
    sequence s_rd(logic [7:0] c);
        rd_req && rd_cmd == c;
    endsequence
    // Sense pin event, then an input status read with no clear beside it
    sequence s_pin_rd;
        cause.vin_ov_pin ##1 (!clear_faults && rd_req && rd_cmd == 8'h7c);
    endsequence
    a_answer_next: assert property (rd_req |=> rd_valid)
        else $error("read not answered");
    a_no_stray: assert property (!rd_req |=> !rd_valid && !rd_err)
        else $error("answer without request");
    a_refuse_code: assert property (rd_req &&
        !(rd_cmd inside {[8'h78:8'h7e], 8'h88, 8'h8b})
        |=> rd_err && rd_data == 16'h0000) else $error("bad code");
    a_pgood_inv: assert property (
        s_rd(8'h79) |=> rd_data[11] != $past(cause.pgood))
        else $error("power good bit wrong");
    a_word_zero: assert property (
        s_rd(8'h79) |=> !rd_data[12] && rd_data[10:9] == 2'h0)
        else $error("reserved word bits set");
    a_word_iout: assert property (
        s_rd(8'h79) ##0 cause.iout_oc |=> rd_data[14])
        else $error("current bit missing");
    a_vout_live: assert property (s_rd(8'h7a) |=>
        rd_data[7] == $past(cause.vout_ov) && rd_data[6:5] == 2'h0 &&
        rd_data[4] == $past(cause.vout_uv) && rd_data[2:1] == 2'h0)
        else $error("output voltage status wrong");
    a_pin_latch: assert property (s_pin_rd |=> rd_data[7])
        else $error("sense pin flag not latched");
    a_vin_reading: assert property (
        s_rd(8'h88) |=> rd_data == 16'($past(vin_meas)))
        else $error("input reading wrong");
    a_vout_reading: assert property (
        s_rd(8'h8b) |=> rd_data == 16'($past(vout_meas)))
        else $error("output reading wrong");
    a_temp_zero: assert property (
        s_rd(8'h7d) |=> rd_data[5:0] == 6'h00 && rd_data[15:8] == 8'h00)
        else $error("temperature reserved bits set");
endmodule

bind psst_bank psst_bank_sva #(.MEAS_WIDTH(MEAS_WIDTH)) psst_bank_sva_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .cause(cause), .comm_err(comm_err),
    .clear_faults(clear_faults), .vin_meas(vin_meas), .vout_meas(vout_meas),
    .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_err(rd_err)
);

/* psst_bank_tb_top.sv */
// Self-checking bench of the status and telemetry register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module psst_bank_tb_top;
    logic sys_clk = 1'h0, rst_b, comm_err, clear_faults, rd_req, rd_valid;
    logic rd_err, m_comm, m_start;
    psst_pkg::psst_cause_type cause;
    psst_pkg::psst_latch_type m_lat;
    logic [9:0] vin_meas, vout_meas;
    logic [7:0] rd_cmd;
    logic [15:0] rd_data;
    logic [16:0] exp_q[$];
    logic [16:0] exp_v;
    logic [7:0] codes[10] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d,
        8'h7e, 8'h88, 8'h8b, 8'h50};
    int num_errors = 0, num_checks = 0, cyc = 0;
    always #4 sys_clk = ~sys_clk;
    psst_host psst_host_inst (.sys_clk(sys_clk), .rd_req(rd_req),
        .rd_cmd(rd_cmd));
    psst_bank psst_bank_inst (.sys_clk(sys_clk), .rst_b(rst_b), .cause(cause),
        .comm_err(comm_err), .clear_faults(clear_faults), .vin_meas(vin_meas),
        .vout_meas(vout_meas), .rd_req(rd_req), .rd_cmd(rd_cmd),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));
    // Reference flags: a latch is set by its cause and cleared by a clear
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            m_lat <= '0;
            m_comm <= 1'h0;
            m_start <= 1'h1;
        end else begin
            m_lat <= (clear_faults ? '0 : m_lat) |
                psst_pkg::psst_latch_type'{cause.vout_other,
                cause.vout_range, cause.iout_oc, cause.iout_oc_uv,
                cause.iout_warn, cause.vin_ov_pin, cause.vin_ov_warn,
                cause.vin_uv_warn, cause.ot_fault, cause.ot_warn,
                cause.other_fault, cause.cmd_bad, cause.data_bad,
                cause.mem_fault, cause.comm_other};
            m_comm <= (clear_faults ? 1'h0 : m_comm) | comm_err;
            m_start <= m_start & !cause.vin_uvlo_ok;
        end
    end
    // Expected refusal flag and data of one code
    function automatic logic [16:0] exp_of(logic [7:0] c);
        logic [7:0] sb;
        psst_pkg::psst_cause_type k;
        psst_pkg::psst_latch_type l;
        k = cause;
        l = m_lat;
        sb = {1'h0, k.disabled, k.vout_ov, l.iout_oc, 1'h0,
            k.ot_fault | k.ot_warn, m_comm, l.other_fault};
        case (c)
            8'h78: exp_of = {9'h0, sb};
            8'h79: exp_of = {1'h0, k.vout_ov | k.vout_uv | l.vout_range |
                l.vout_other, k.iout_oc, m_start, 1'h0, !k.pgood, 2'h0,
                l.other_fault, sb};
            8'h7a: exp_of = {9'h0, k.vout_ov, 2'h0, k.vout_uv, l.vout_range,
                2'h0, l.vout_other};
            8'h7b: exp_of = {9'h0, l.iout_oc, l.iout_oc_uv, l.iout_warn, 5'h0};
            8'h7c: exp_of = {9'h0, l.vin_ov_pin, l.vin_ov_warn,
                l.vin_uv_warn, 5'h0};
            8'h7d: exp_of = {9'h0, l.ot_fault, l.ot_warn, 6'h0};
            8'h7e: exp_of = {9'h0, l.cmd_bad, l.data_bad, 1'h0, l.mem_fault,
                2'h0, l.comm_other, k.mem_busy};
            8'h88: exp_of = {7'h0, vin_meas};
            8'h8b: exp_of = {7'h0, vout_meas};
            default: exp_of = 17'h10000;
        endcase
    endfunction
    // Issue one read and note what it must return
    task automatic rd(input logic [7:0] c);
        psst_host_inst.issue(c);
        #1 exp_q.push_back(exp_of(c));
    endtask
    // Causes settle four cycles before reads, so latches are in place
    task automatic apply(input psst_pkg::psst_cause_type c,
        input logic clr, input logic err, input logic all);
        @(posedge sys_clk);
        cause <= c;
        comm_err <= err;
        @(posedge sys_clk);
        comm_err <= 1'h0;
        clear_faults <= clr;
        @(posedge sys_clk);
        clear_faults <= 1'h0;
        @(posedge sys_clk);
        if (all) begin
            foreach (codes[j]) rd(codes[j]);
        end else begin
            rd(8'h7e);
        end
        psst_host_inst.release_bus();
    endtask
    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Answers are taken mid-cycle, away from the launching edge
    always @(negedge sys_clk) begin
        if (rd_valid === 1'h1) begin
            // Pop once: the macro names its expected value twice
            exp_v = exp_q.pop_front();
            `CHK("read", exp_v, {rd_err, rd_data})
        end
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'hc7ef));
        {rst_b, comm_err, clear_faults, vin_meas, vout_meas} = '0;
        cause = '0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'h1;
        apply('0, 1'h0, 1'h0, 1'h1);
        for (int i = 0; i < 30; i++) begin
            vin_meas <= 10'($urandom);
            vout_meas <= 10'($urandom);
            apply(21'($urandom) & 21'h1fffe0, 1'($urandom), 1'($urandom), 1'h1);
        end
        apply('0, 1'h1, 1'h0, 1'h1);
        apply(21'h1f, 1'h0, 1'h0, 1'h0);
        repeat (3) @(posedge sys_clk);
        finish_test();
    end
endmodule

/* psst_host.sv */
// Management bus host model issuing register reads
`timescale 1ns/1ps
module psst_host (
    input wire logic sys_clk, // Clock
    output logic rd_req, // Read request
    output logic [7:0] rd_cmd // Command code
);
    initial begin
        rd_req = 1'h0;
        rd_cmd = 8'h00;
    end
    // Raised after an edge; a following call keeps it up back to back
    task automatic issue(input logic [7:0] c);
        @(posedge sys_clk);
        rd_req <= 1'h1;
        rd_cmd <= c;
    endtask
    // Idle code is scrambled so a stale code is never trusted
    task automatic release_bus();
        @(posedge sys_clk);
        rd_req <= 1'h0;
        rd_cmd <= ~rd_cmd;
    endtask
endmodule

/* psst_pkg.sv */
// Package for the power stage status and telemetry register bank
package psst_pkg;
    // Command codes of the readable registers
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;
    localparam logic [7:0] CMD_IOUT_STATUS = 8'h7b;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
    localparam logic [7:0] CMD_COMM_STATUS = 8'h7e;
    localparam logic [7:0] CMD_VIN_READING = 8'h88;
    localparam logic [7:0] CMD_VOUT_READING = 8'h8b;

    // Measurement width and scale
    localparam int MEAS_W = 10;
    localparam real VOUT_LSB_MV = 1.25;

    // Bit positions in the summary word high byte
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_VIN = 13;
    localparam int SW_PGOOD_N = 11;
    localparam int SW_OTHER = 8;
    // Bit positions in the status byte
    localparam int SB_OFF = 6;
    localparam int SB_VOUT_OV = 5;
    localparam int SB_IOUT_OC = 4;
    localparam int SB_TEMP = 2;
    localparam int SB_COMM = 1;
    localparam int SB_NONE = 0;
    // Bit positions of byte-wide status fields
    localparam int B7 = 7;
    localparam int B6 = 6;
    localparam int B5 = 5;
    localparam int B4 = 4;
    localparam int B3 = 3;
    localparam int B1 = 1;
    localparam int B0 = 0;

    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ZERO8 = 8'h00;

    // Fault and warning causes from the analog side
    typedef struct packed {
        logic vout_ov;
        logic vout_uv;
        logic vout_range;
        logic vout_other;
        logic iout_oc;
        logic iout_oc_uv;
        logic iout_warn;
        logic vin_ov_pin;
        logic vin_ov_warn;
        logic vin_uv_warn;
        logic vin_uvlo_ok;
        logic ot_fault;
        logic ot_warn;
        logic other_fault;
        logic pgood;
        logic disabled;
        logic cmd_bad;
        logic data_bad;
        logic mem_fault;
        logic comm_other;
        logic mem_busy;
    } psst_cause_type;

    // Latched flags
    typedef struct packed {
        logic vout_other;
        logic vout_range;
        logic iout_oc;
        logic iout_oc_uv;
        logic iout_warn;
        logic vin_ov_pin;
        logic vin_ov_warn;
        logic vin_uv_warn;
        logic ot_fault;
        logic ot_warn;
        logic other_fault;
        logic cmd_bad;
        logic data_bad;
        logic mem_fault;
        logic comm_other;
    } psst_latch_type;

    // Module state except the bus error latch
    typedef struct packed {
        psst_latch_type lat;
        logic vin_startup;
        logic [15:0] rdata;
        logic rvalid;
        logic rerr;
    } psst_state_type;
endpackage
